// ---- flash_guard_pkg.sv ----
// constants, opcodes and status layout for the serial flash command front end
// assumes a single system clock at the rate named below; no timescale here
package flash_guard_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_SR1 = 8'h05;
  localparam logic [7:0] OP_READ_SR2 = 8'h35;
  localparam logic [7:0] OP_READ_SR3 = 8'h15;
  localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
  localparam logic [7:0] OP_WRITE_SR3 = 8'h11;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE_PD = 8'hab;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;

  // ==========================================================================
  // status bit positions and reset values
  localparam int SR1_BUSY_BIT = 0;
  localparam int SR1_WEL_BIT = 1;
  localparam int SR1_BP_LSB = 2;
  localparam int SR1_TB_BIT = 5;
  localparam int SR1_SEC_BIT = 6;
  localparam int SR1_SRP_BIT = 7;
  localparam int SR2_SRL_BIT = 0;
  localparam int SR2_QE_BIT = 1;
  localparam int SR2_CMP_BIT = 6;
  localparam int SR3_WPS_BIT = 2;
  localparam logic [2:0] BP_RESET = 3'h0;
  localparam logic FLAG_RESET = 1'b0;

  // ==========================================================================
  // framing and geometry
  localparam logic [4:0] OPC_LAST_BIT = 5'h07;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
  localparam logic [5:0] LAST_BLOCK = 6'h3f;
  localparam int LOCK_SECTORS = 32;
  localparam int LOCK_BLOCKS = 62;
  localparam int LOCK_BITS = LOCK_SECTORS + LOCK_BLOCKS;
  localparam logic [LOCK_BITS-1:0] LOCK_RESET = {LOCK_BITS{1'b1}};

  // ==========================================================================
  // timing
  localparam int SYS_CLK_MHZ = 20;
  localparam int T_SW_RESET_NS = 30000;
  localparam int SW_RESET_CYCLES = (T_SW_RESET_NS * SYS_CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // front end states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_OPC   = 7'b000_0010,
    ST_ADDR  = 7'b000_0100,
    ST_DUMMY = 7'b000_1000,
    ST_DIN   = 7'b001_0000,
    ST_DOUT  = 7'b010_0000,
    ST_WAIT  = 7'b100_0000
  } st_t;

endpackage

// ---- pin_sync.sv ----
// two-stage synchroniser with edge detection for pins from outside sys_clk
// assumes inputs change slower than a few system clocks
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // ==========================================================================
  // first stage feeds only the second; edges come from stages two and three
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= INIT;
      sync_q <= INIT;
      prev_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// ---- flash_guard.sv ----
// serial flash command front end: opcode capture, gating and write protection
// assumes the host clock is at least 8 system clocks per period
`timescale 1ns/100ps

module flash_guard import flash_guard_pkg::*; #(
  parameter int PUW_CYCLES = 20000,
  parameter int BUSY_CYCLES = 200,
  parameter logic [7:0] FILL_BYTE = 8'hff
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reset_pin_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe
);

  // ==========================================================================
  // decode helpers
  function automatic logic is_prog(input logic [7:0] op);
    return op == OP_PAGE_PROG || op == OP_QUAD_PROG;
  endfunction
  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_SECT_ERASE || op == OP_BLK32_ERASE || op == OP_BLK64_ERASE ||
           op == OP_CHIP_ERASE || op == OP_CHIP_ERASE_ALT;
  endfunction
  function automatic logic is_chip(input logic [7:0] op);
    return op == OP_CHIP_ERASE || op == OP_CHIP_ERASE_ALT;
  endfunction
  function automatic logic is_wsr(input logic [7:0] op);
    return op == OP_WRITE_SR1 || op == OP_WRITE_SR2 || op == OP_WRITE_SR3;
  endfunction
  function automatic logic is_rsr(input logic [7:0] op);
    return op == OP_READ_SR1 || op == OP_READ_SR2 || op == OP_READ_SR3;
  endfunction
  function automatic logic is_read(input logic [7:0] op);
    return op == OP_READ || op == OP_FAST_READ || op == OP_DUAL_OUT || op == OP_DUAL_IO ||
           op == OP_QUAD_OUT || op == OP_QUAD_IO;
  endfunction
  function automatic logic is_lockop(input logic [7:0] op);
    return op == OP_BLOCK_UNLOCK || op == OP_BLOCK_LOCK;
  endfunction
  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    return (op == OP_DUAL_IO) ? 3'h2 : (op == OP_QUAD_IO) ? 3'h4 : 3'h1;
  endfunction
  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    if (op == OP_DUAL_OUT || op == OP_DUAL_IO) begin
      return 3'h2;
    end
    return (op == OP_QUAD_OUT || op == OP_QUAD_IO || op == OP_QUAD_PROG) ? 3'h4 : 3'h1;
  endfunction
  function automatic logic [3:0] dummy_of(input logic [7:0] op);
    if (op == OP_FAST_READ || op == OP_DUAL_OUT || op == OP_QUAD_OUT) begin
      return DUMMY_FAST;
    end
    return (op == OP_DUAL_IO) ? DUMMY_DUAL_IO : (op == OP_QUAD_IO) ? DUMMY_QUAD_IO : 4'h0;
  endfunction
  function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] ln, input logic [3:0] io);
    if (ln == 3'h4) begin
      return {v[19:0], io};
    end
    return (ln == 3'h2) ? {v[21:0], io[1:0]} : {v[22:0], io[0]};
  endfunction
  // edge sectors 0..31, middle blocks from 32 upward
  function automatic logic [6:0] lock_index(input logic [23:0] a);
    if (a[21:16] == 6'h00) begin
      return {3'h0, a[15:12]};
    end
    if (a[21:16] == LAST_BLOCK) begin
      return {3'h1, a[15:12]};
    end
    return 7'(LOCK_SECTORS) + {1'b0, a[21:16]} - 7'h01;
  endfunction

  // ==========================================================================
  // pin synchronisers; hardware reset pin idles high
  logic [6:0] pin_lvl;
  logic [6:0] pin_rise;
  logic [6:0] pin_fall;
  pin_sync #(.WIDTH(7), .INIT(7'h60)) u_sync (
    .clk(sys_clk),
    .rstn(rstn),
    .din({reset_pin_n, cs_n, sclk, io_in}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  st_t st_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [7:0] din_q;
  logic [4:0] cnt_q;
  logic [2:0] lanes_q;
  logic [3:0] dummy_q;
  logic armed_q;
  logic wel_q;
  logic busy_q;
  logic pd_q;
  logic arm_rst_q;
  logic [31:0] busy_cnt_q;
  logic [31:0] puw_cnt_q;
  logic [9:0] rst_cnt_q;
  logic [2:0] bp_q;
  logic tb_q;
  logic sec_q;
  logic srp_q;
  logic srl_q;
  logic qe_q;
  logic cmp_q;
  logic wps_q;
  logic [LOCK_BITS-1:0] lock_q;
  logic [7:0] out_byte_q;
  logic [3:0] out_left_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_q;

  // ==========================================================================
  // pin roles; edges only count while selected so either idle clock level works
  wire [3:0] io_s = pin_lvl[3:0];
  wire sel = !pin_lvl[5];
  wire sclk_rise = sel && pin_rise[4];
  wire sclk_fall = sel && pin_fall[4];
  wire cs_fall = pin_fall[5];
  wire cs_rise = pin_rise[5];
  wire hw_rst = !pin_lvl[6];
  wire wp_n = io_s[2];

  // ==========================================================================
  // instruction gating at the eighth opcode bit
  wire [7:0] op_new = {opc_q[6:0], io_s[0]};
  wire rst_active = rst_cnt_q != 10'h000;
  wire puw_active = puw_cnt_q != 32'h0;
  wire opc_last = st_q == ST_OPC && sclk_rise && cnt_q == OPC_LAST_BIT;
  wire need_wel = is_prog(op_new) || is_erase(op_new) || is_wsr(op_new) || is_lockop(op_new);
  wire puw_block = op_new == OP_WRITE_ENABLE || is_prog(op_new) || is_erase(op_new) || is_wsr(op_new);
  wire need_quad = op_new == OP_QUAD_OUT || op_new == OP_QUAD_IO || op_new == OP_QUAD_PROG;
  wire busy_ok = is_rsr(op_new) || op_new == OP_SUSPEND;
  wire op_allowed = rst_active ? 1'b0 :
                    pd_q ? (op_new == OP_RELEASE_PD) :
                    busy_q ? busy_ok :
                    !(puw_active && puw_block) &&
                    !(need_wel && !wel_q) && !(need_quad && !qe_q);
  wire cmd_accept = opc_last && op_allowed;
  wire [4:0] cnt_step = cnt_q + {2'b00, lanes_q};
  wire [23:0] addr_next = shift_in(addr_q, lanes_q, io_s);
  wire [23:0] din_next = shift_in({16'h0000, din_q}, lanes_q, io_s);

  // ==========================================================================
  // protection decisions at chip select rise
  wire exec = cs_rise && armed_q;
  wire [6:0] lidx = lock_index(addr_q);
  wire region_locked = is_chip(opc_q) ? (|lock_q) : lock_q[lidx];
  wire bp_prot = (bp_q != 3'h0) ^ cmp_q;
  wire array_prot = wps_q ? region_locked : bp_prot;
  wire sr_locked = srl_q || (srp_q && !wp_n && !qe_q);
  wire array_go = exec && (is_prog(opc_q) || is_erase(opc_q)) && !array_prot;
  wire sr_go = exec && is_wsr(opc_q) && !sr_locked;
  wire busy_start = array_go || sr_go;
  wire sw_reset_go = exec && opc_q == OP_RESET && arm_rst_q;
  wire [7:0] sr1 = {srp_q, sec_q, tb_q, bp_q, wel_q, busy_q};
  wire [7:0] sr2 = {1'b0, cmp_q, 4'h0, qe_q, srl_q};
  wire [7:0] sr3 = {5'h00, wps_q, 2'h0};
  wire [7:0] src_byte = (opc_q == OP_READ_SR1) ? sr1 : (opc_q == OP_READ_SR2) ? sr2 :
                        (opc_q == OP_READ_SR3) ? sr3 : FILL_BYTE;

  // ==========================================================================
  // framing state machine; select rise always aborts back to idle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      opc_q <= 8'h00;
      addr_q <= 24'h00_0000;
      din_q <= 8'h00;
      cnt_q <= 5'h00;
      lanes_q <= 3'h1;
      dummy_q <= 4'h0;
      armed_q <= 1'b0;
    end else if (hw_rst || cs_rise) begin
      st_q <= ST_IDLE;
      armed_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (cs_fall) begin
            st_q <= ST_OPC;
            cnt_q <= 5'h00;
            lanes_q <= 3'h1;
          end
        end
        ST_OPC: begin
          if (sclk_rise) begin
            opc_q <= op_new;
            cnt_q <= cnt_q + 5'h01;
            dummy_q <= dummy_of(op_new);
            if (cnt_q == OPC_LAST_BIT) begin
              cnt_q <= 5'h00;
              if (!op_allowed) begin
                st_q <= ST_WAIT;
              end else if (is_read(op_new) || is_prog(op_new) || is_lockop(op_new) ||
                           (is_erase(op_new) && !is_chip(op_new))) begin
                st_q <= ST_ADDR;
                lanes_q <= addr_lanes(op_new);
              end else if (is_wsr(op_new)) begin
                st_q <= ST_DIN;
              end else if (is_rsr(op_new)) begin
                st_q <= ST_DOUT;
              end else begin
                st_q <= ST_WAIT;
                armed_q <= 1'b1;
              end
            end
          end
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            addr_q <= addr_next;
            cnt_q <= cnt_step;
            if (cnt_step == ADDR_BITS) begin
              cnt_q <= 5'h00;
              lanes_q <= data_lanes(opc_q);
              if (is_read(opc_q)) begin
                st_q <= (dummy_q == 4'h0) ? ST_DOUT : ST_DUMMY;
              end else begin
                st_q <= is_prog(opc_q) ? ST_DIN : ST_WAIT;
                armed_q <= 1'b1;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (sclk_rise) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q + 5'h01 == {1'b0, dummy_q}) begin
              st_q <= ST_DOUT;
            end
          end
        end
        ST_DIN: begin
          if (sclk_rise) begin
            din_q <= din_next[7:0];
            cnt_q <= (cnt_step == BYTE_BITS) ? 5'h00 : cnt_step;
            if (cnt_step == BYTE_BITS && is_wsr(opc_q)) begin
              st_q <= ST_WAIT; // extra status bytes ignored
              armed_q <= 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // latch, busy, power-down and reset timers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wel_q <= FLAG_RESET;
      busy_q <= 1'b0;
      pd_q <= 1'b0;
      arm_rst_q <= 1'b0;
      busy_cnt_q <= 32'h0;
      rst_cnt_q <= 10'h000;
      puw_cnt_q <= 32'(PUW_CYCLES);
    end else if (hw_rst) begin
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      pd_q <= 1'b0;
      arm_rst_q <= 1'b0;
      rst_cnt_q <= 10'h000;
    end else begin
      puw_cnt_q <= puw_active ? puw_cnt_q - 32'h1 : puw_cnt_q;
      rst_cnt_q <= rst_active ? rst_cnt_q - 10'h001 : rst_cnt_q;
      // reset-enable only survives until the very next instruction
      if (cs_rise && st_q != ST_IDLE && st_q != ST_OPC) begin
        arm_rst_q <= armed_q && opc_q == OP_RESET_ENABLE;
      end
      if (exec && opc_q == OP_WRITE_ENABLE) begin
        wel_q <= 1'b1;
      end
      if ((exec && opc_q == OP_WRITE_DISABLE) || busy_start) begin
        wel_q <= 1'b0;
      end
      if (exec && opc_q == OP_POWER_DOWN) begin
        pd_q <= 1'b1;
      end
      if (exec && opc_q == OP_RELEASE_PD) begin
        pd_q <= 1'b0;
      end
      if (busy_start) begin
        busy_q <= 1'b1;
        busy_cnt_q <= 32'(BUSY_CYCLES - 1);
      end else if (busy_q) begin
        busy_cnt_q <= busy_cnt_q - 32'h1;
        if (busy_cnt_q == 32'h0) begin
          busy_q <= 1'b0;
          wel_q <= 1'b0;
        end
      end
      if (sw_reset_go) begin
        rst_cnt_q <= 10'(SW_RESET_CYCLES);
        wel_q <= 1'b0;
        busy_q <= 1'b0;
        pd_q <= 1'b0;
        arm_rst_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // status bits; srl only drops on a power cycle, so hardware reset keeps it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bp_q <= BP_RESET;
      {tb_q, sec_q, srp_q, srl_q, qe_q, cmp_q, wps_q} <= {7{FLAG_RESET}};
    end else if (sr_go && opc_q == OP_WRITE_SR1) begin
      bp_q <= din_q[SR1_BP_LSB+2:SR1_BP_LSB];
      tb_q <= din_q[SR1_TB_BIT];
      sec_q <= din_q[SR1_SEC_BIT];
      srp_q <= din_q[SR1_SRP_BIT];
    end else if (sr_go && opc_q == OP_WRITE_SR2) begin
      srl_q <= srl_q || din_q[SR2_SRL_BIT];
      qe_q <= din_q[SR2_QE_BIT];
      cmp_q <= din_q[SR2_CMP_BIT];
    end else if (sr_go && opc_q == OP_WRITE_SR3) begin
      wps_q <= din_q[SR3_WPS_BIT];
    end
  end

  // ==========================================================================
  // per-region lock bits, all set by any reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= LOCK_RESET;
    end else if (hw_rst || sw_reset_go) begin
      lock_q <= LOCK_RESET;
    end else if (exec && is_lockop(opc_q)) begin
      lock_q[lidx] <= (opc_q == OP_BLOCK_LOCK);
    end
  end

  // ==========================================================================
  // output lanes: new bits on each falling edge, released at deselect
  wire [7:0] cur_byte = (out_left_q == 4'h0) ? src_byte : out_byte_q;
  wire [3:0] lane_bits = (lanes_q == 3'h4) ? cur_byte[7:4] :
                         (lanes_q == 3'h2) ? {2'b00, cur_byte[7:6]} : {2'b00, cur_byte[7], 1'b0};
  wire [3:0] lane_oe = (lanes_q == 3'h4) ? 4'hf : (lanes_q == 3'h2) ? 4'h3 : 4'h2;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
      out_byte_q <= 8'h00;
      out_left_q <= 4'h0;
    end else if (hw_rst || cs_rise || st_q != ST_DOUT) begin
      io_oe_q <= 4'h0;
      out_left_q <= 4'h0;
    end else if (sclk_fall) begin
      io_out_q <= lane_bits;
      io_oe_q <= lane_oe;
      out_byte_q <= cur_byte << lanes_q;
      out_left_q <= ((out_left_q == 4'h0) ? 4'h8 : out_left_q) - {1'b0, lanes_q};
    end
  end

  assign io_out = io_out_q;
  assign io_oe = io_oe_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence reset_window;
    rst_cnt_q == 10'(SW_RESET_CYCLES) ##1 rst_active [*4];
  endsequence

  a_pd_release_only: assert property (pd_q && cmd_accept |-> op_new == OP_RELEASE_PD)
    else $error("power-down accepted a non-release instruction");
  a_busy_filter: assert property (busy_q && cmd_accept |-> is_rsr(op_new) || op_new == OP_SUSPEND)
    else $error("busy device accepted a blocked instruction");
  a_reset_reject: assert property (rst_active |-> !cmd_accept)
    else $error("instruction accepted during software reset");
  a_sw_reset_seq: assert property (sw_reset_go && !hw_rst |=> reset_window)
    else $error("software reset period not started");
  a_wel_before_write: assert property ($rose(busy_q) |-> $past(wel_q))
    else $error("write operation started without latch");
  a_wel_after_done: assert property (disable iff (!rstn || hw_rst) $fell(busy_q) |-> !wel_q)
    else $error("latch still set after completion");
  a_busy_hold: assert property (disable iff (!rstn || hw_rst || sw_reset_go) $rose(busy_q) |-> busy_q [*8])
    else $error("busy dropped too early");
  a_puw_wel_clear: assert property (puw_active |-> !wel_q)
    else $error("latch set during power-up write delay");
  a_dout_on_fall: assert property ($changed(io_out_q) |-> $past(sclk_fall))
    else $error("output changed away from a falling edge");
  a_quad_needs_qe: assert property (io_oe_q[3] |-> qe_q && lanes_q == 3'h4)
    else $error("line 3 driven without quad enable");
  a_hw_reset_wins: assert property (hw_rst |=> st_q == ST_IDLE && !busy_q && io_oe_q == 4'h0)
    else $error("hardware reset did not take precedence");
  a_sr_lock_gate: assert property (srp_q && !srl_q && !qe_q && !wp_n && exec && is_wsr(opc_q) |-> !busy_start)
    else $error("status write went through a locked register");

endmodule

// ---- spi_host.sv ----
// spi host model: clock, select, line 0 and the write-protect line; reads line 1
// assumes the bench clock; one serial half period is 4 system cycles
`timescale 1ns/100ps
module spi_host (
  input wire logic sys_clk,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic [3:0] io_in
);
  logic mode3 = 1'b0;
  logic io0 = 1'b0;
  logic wp_n = 1'b1;
  logic io3 = 1'b1;
  logic [3:0] oe_seen = 4'h0;
  // released line 1 shows the inverse of its last value, never a kind guess
  assign io_in = {io3, wp_n, io_oe[1] ? io_out[1] : ~io_out[1], io0};
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk) #1;
  endtask
  // =====================================================
  // frame: opcode then nb bytes, msb first; samples mid high phase
  task automatic frame(input logic [7:0] op, input logic [7:0] wr, input int nb,
                       output logic [7:0] rd, output logic oe);
    logic [15:0] sh;
    sh = {op, wr};
    oe = 1'b0;
    oe_seen = 4'h0;
    rd = 8'h00;
    sclk = mode3;
    tick(2);
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      sclk = 1'b0;
      io0 = (i < 16) ? sh[15-i] : 1'b0;
      tick(4);
      sclk = 1'b1;
      tick(2);
      rd = {rd[6:0], io_in[1]};
      oe = oe | io_oe[1];
      oe_seen = oe_seen | io_oe;
      tick(2);
    end
    sclk = mode3;
    tick(4);
    cs_n = 1'b1;
    tick(10);
  endtask
endmodule

// ---- testbench.sv ----
// bench for the flash command front end: status, protection and wide read paths
// assumes the spi_host model drives the link; all waits are fixed counts
`timescale 1ns/100ps
module testbench import flash_guard_pkg::*;;
  logic sys_clk, rstn, reset_pin_n, sclk, cs_n, oe;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] rd;
  int n_errors = 0;
  int checked = 0;
  // busy made long so a status read lands inside it
  flash_guard #(.PUW_CYCLES(200), .BUSY_CYCLES(400)) uut (.sys_clk(sys_clk),
    .rstn(rstn), .reset_pin_n(reset_pin_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  spi_host host (.sys_clk(sys_clk), .io_out(io_out), .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    host.frame(c, 8'h00, 0, rd, oe);
  endtask
  task automatic rd_sr;
    host.frame(OP_READ_SR1, 8'h00, 1, rd, oe);
  endtask
  task automatic summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // =====================================================
  // scenarios in order; each leans on the state left by the last
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic t_power_up;
    op(OP_WRITE_ENABLE);
    rd_sr;
    chk(rd, 8'h00);
    chk({7'h0, oe}, 8'h01);
    host.tick(200);
    op(OP_WRITE_ENABLE);
    rd_sr;
    chk(rd, 8'h02);
    $display("power up done");
  endtask
  // busy outlasts three frames, so a wrongly taken latch set would show while still busy
  task automatic t_status_write;
    host.frame(OP_WRITE_SR1, 8'h1c, 1, rd, oe);
    rd_sr;
    chk(rd & 8'h03, 8'h01);
    op(OP_WRITE_ENABLE);
    rd_sr;
    chk(rd & 8'h03, 8'h01);
    host.tick(400);
    rd_sr;
    chk(rd, 8'h1c);
    host.mode3 = 1'b1;
    rd_sr;
    chk(rd, 8'h1c);
    host.mode3 = 1'b0;
    $display("status write done");
  endtask
  task automatic t_sw_reset;
    op(OP_RESET);
    rd_sr;
    chk({7'h0, oe}, 8'h01);
    op(OP_RESET_ENABLE);
    op(OP_RESET);
    rd_sr;
    chk({7'h0, oe}, 8'h00);
    host.tick(SW_RESET_CYCLES);
    rd_sr;
    chk({7'h0, oe}, 8'h01);
    $display("software reset done");
  endtask
  task automatic t_power_down;
    op(OP_POWER_DOWN);
    op(OP_WRITE_ENABLE);
    rd_sr;
    chk({7'h0, oe}, 8'h00);
    op(OP_RELEASE_PD);
    rd_sr;
    chk(rd, 8'h1c);
    $display("power down done");
  endtask
  task automatic t_hw_reset;
    op(OP_WRITE_ENABLE);
    reset_pin_n = 1'b0;
    host.tick(20);
    reset_pin_n = 1'b1;
    host.tick(5);
    rd_sr;
    chk(rd, 8'h1c);
    $display("hardware reset done");
  endtask
  // block-protect bits survive the pin reset, so a program is dropped and the latch kept
  task automatic t_array_protect;
    op(OP_WRITE_ENABLE);
    host.frame(OP_PAGE_PROG, 8'h00, 3, rd, oe);
    rd_sr;
    chk(rd, 8'h1e);
    $display("array protect done");
  endtask
  task automatic t_write_protect;
    host.frame(OP_WRITE_SR1, 8'h9c, 1, rd, oe);
    host.tick(450);
    host.wp_n = 1'b0;
    op(OP_WRITE_ENABLE);
    host.frame(OP_WRITE_SR1, 8'h1c, 1, rd, oe);
    rd_sr;
    chk(rd, 8'h9e);
    host.wp_n = 1'b1;
    host.frame(OP_WRITE_SR1, 8'h1c, 1, rd, oe);
    host.tick(450);
    rd_sr;
    chk(rd, 8'h1c);
    $display("write protect done");
  endtask
  // wide reads return the fill byte; quad stays refused until quad enable is set
  task automatic t_wide_reads;
    host.frame(OP_DUAL_OUT, 8'h00, 5, rd, oe);
    chk(rd, 8'hff);
    chk({4'h0, host.oe_seen}, 8'h03);
    host.frame(OP_QUAD_OUT, 8'h00, 5, rd, oe);
    chk({4'h0, host.oe_seen}, 8'h00);
    op(OP_WRITE_ENABLE);
    host.frame(OP_WRITE_SR2, 8'h02, 1, rd, oe);
    host.tick(450);
    host.frame(OP_QUAD_OUT, 8'h00, 5, rd, oe);
    chk(rd, 8'hff);
    chk({4'h0, host.oe_seen}, 8'h0f);
    $display("wide reads done");
  endtask
  initial begin
    rstn = 1'b0;
    reset_pin_n = 1'b1;
    host.tick(8);
    rstn = 1'b1;
    t_power_up;
    t_status_write;
    t_sw_reset;
    t_power_down;
    t_hw_reset;
    t_array_protect;
    t_write_protect;
    t_wide_reads;
    summarize;
  end
endmodule
